// >>> design/cfg_eeprom_consts.svh
// named constants for the configuration eeprom access block
`ifndef CFG_EEPROM_CONSTS_SVH
`define CFG_EEPROM_CONSTS_SVH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define CLK_MHZ          200
`define TWR_MS           20
`define TEC_MS           25

// ------------------------------------------------------------
// 2-wire address map and byte values
// ------------------------------------------------------------
`define DEV_ADDR_DEF     7'h50
`define SEC_BASE         24'h800000
`define ERASE_ADDR       24'h800010
`define SEC_LAST_IDX     2'h3
`define ADDR_LAST_IDX    2'h2
`define ZERO_PASSES      2'h2
`define BYTE_ONES        8'hff
`define BYTE_ZERO        8'h00
`define BYTE_BITS        4'h8
`define MASK_FULL        4'hf

`endif

// >>> design/cfg_eeprom_pkg.sv
// types shared by the configuration eeprom access block
package cfg_eeprom_pkg;

  // gray coded along idle, address, ack, data
  typedef enum logic [3:0]
  {
    TW_IDLE    = 4'h0,
    TW_DEV     = 4'h1,
    TW_DEV_ACK = 4'h3,
    TW_ADR     = 4'h2,
    TW_ADR_ACK = 4'h6,
    TW_WR      = 4'h7,
    TW_WR_ACK  = 4'h5,
    TW_RD      = 4'h4,
    TW_RD_ACK  = 4'hc
  } tw_state_e;

endpackage

// >>> design/cfg_mem_array.sv
// byte wide array with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none

module cfg_mem_array #(
  parameter int ADDR_W = 17
) (
  // clock
  input  wire logic              clk,
  // write port
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [7:0]        wdata,
  // read port
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [7:0]        rdata
);

  typedef struct packed {
    logic [7:0] rdata;
  } mem_s;

  logic [7:0] cells [0:(1<<ADDR_W)-1];
  mem_s       q;
  mem_s       next_q;

  always_comb
  begin
    next_q       = q;
    next_q.rdata = cells[raddr];
  end

  // no reset: contents and read data are nonvolatile-like storage
  always_ff @(posedge clk)
  begin
    q <= next_q;
    if (we)
    begin
      cells[waddr] <= wdata;
    end
  end

  assign rdata = q.rdata;

endmodule

`default_nettype wire

// >>> design/cfg_eeprom.sv
// configuration eeprom: serial read-out, 2-wire programming, fuse and erase
// How it works
// [RULE1] config mode drives data only when selected
// [RULE2] reset level holds address and bit counters
// [RULE3] reset input polarity is strap selectable
// [RULE4] deselect stops counters, enters low power
// [RULE5] programming mode ignores chip select
// [RULE6] select low enters 2-wire programming
// [RULE7] external serial clock advances the counters
// [RULE8] three-state read-out, open-drain programming line
// [RULE9] set fuse mutes normal data output
// [RULE10] clearing a set fuse erases array
// [RULE11] programmer writes zeros twice to disable
// [RULE12] disable applies on reset or select toggle
// [RULE13] programmer writes ones to enable fuse
// [RULE14] security reads return fuse as bytes
// [RULE15] write to erase address erases all
// [RULE16] erase finishes within erase cycle time
// [RULE17] 2-wire address kept between operations
// [RULE18] no address acknowledge while busy
`timescale 1ns/1ps
`default_nettype none
`include "cfg_eeprom_consts.svh"

module cfg_eeprom #(
  parameter int          ADDR_W   = 17,
  parameter logic [6:0]  DEV_ADDR = `DEV_ADDR_DEF,
  parameter int unsigned WR_CYC   = `TWR_MS * 1000 * `CLK_MHZ,
  parameter int unsigned ERASE_CYC = `TEC_MS * 1000 * `CLK_MHZ
) (
  // system
  input  wire logic mclk,
  input  wire logic rstn,
  // link clock from the far party
  input  wire logic config_serial_clock,
  // data line, split
  input  wire logic config_data_in,
  output logic      config_data_out,
  output logic      config_data_oe,
  // control pins
  input  wire logic chip_select_n,
  input  wire logic counter_reset_oe,
  input  wire logic reset_active_high,
  input  wire logic programming_select_n,
  // status
  output logic      low_power
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                prog_sy;
    logic [1:0]                ce_sy;
    logic [1:0]                rst_sy;
    logic [1:0]                pol_sy;
    logic [1:0]                scl_sy;
    logic [1:0]                sda_sy;
    logic [ADDR_W-1:0]         g1;
    logic [ADDR_W-1:0]         g2;
    logic                      scl_d;
    logic                      sda_d;
    logic                      prog_d;
    logic                      low_power;
    logic                      cfg_drive;
    logic                      link_rstn;
    cfg_eeprom_pkg::tw_state_e st;
    logic [3:0]                bitc;
    logic [7:0]                sh;
    logic                      rw;
    logic [1:0]                adr_idx;
    logic [23:0]               addr;
    logic                      sda_low;
    logic                      wrote;
    logic [3:0]                zmask;
    logic [3:0]                fmask;
    logic [1:0]                zpass;
    logic                      fuse;
    logic                      clr_pend;
    logic [31:0]               busy_cnt;
    logic                      erasing;
    logic [ADDR_W-1:0]         erase_addr;
  } m_s;

  typedef struct packed {
    logic [2:0]        bitc;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] gray;
    logic [7:0]        sh;
  } l_s;

  typedef struct packed {
    logic [7:0] d1;
    logic [7:0] d2;
  } d_s;

  m_s                m;
  m_s                next_m;
  l_s                l;
  l_s                next_l;
  d_s                d;
  d_s                next_d;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0]        mem_wd;
  logic [ADDR_W-1:0] mem_ra;
  logic [7:0]        mem_rd;
  logic              prog;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_c;
  logic              stop_c;
  logic              busy;
  logic              sec_hit;
  logic [7:0]        rx_byte;
  logic [7:0]        rd_byte;
  logic [ADDR_W-1:0] cfg_addr;

  function automatic logic [ADDR_W-1:0] gray2bin(input logic [ADDR_W-1:0] g);
    logic [ADDR_W-1:0] b;
    b[ADDR_W-1] = g[ADDR_W-1];
    for (int i = ADDR_W - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  cfg_mem_array #(
    .ADDR_W (ADDR_W)
  ) u_mem (
    .clk   (mclk),
    .we    (mem_we),
    .waddr (mem_wa),
    .wdata (mem_wd),
    .raddr (mem_ra),
    .rdata (mem_rd)
  );

  // ------------------------------------------------------------
  // system clock side: pins, 2-wire engine, fuse, erase
  // ------------------------------------------------------------
  assign prog     = ~m.prog_sy[1];  // see [RULE6]
  assign scl_rise = m.scl_sy[1] & ~m.scl_d;
  assign scl_fall = ~m.scl_sy[1] & m.scl_d;
  assign start_c  = m.scl_sy[1] & m.scl_d & m.sda_d & ~m.sda_sy[1];
  assign stop_c   = m.scl_sy[1] & m.scl_d & ~m.sda_d & m.sda_sy[1];
  assign busy     = (m.busy_cnt != 32'h0);
  assign sec_hit  = (m.addr[23:2] == `SEC_BASE >> 2);
  assign rd_byte  = sec_hit ? {8{m.fuse}} : mem_rd;  // see [RULE14]
  assign cfg_addr = gray2bin(m.g2);
  assign mem_ra   = prog ? m.addr[ADDR_W-1:0] : cfg_addr;
  assign rx_byte  = {<<{m.sh}};  // data bytes travel lsb first

  always_comb
  begin
    next_m         = m;
    mem_we         = 1'b0;
    mem_wa         = m.addr[ADDR_W-1:0];
    mem_wd         = rx_byte;
    next_m.prog_sy = {m.prog_sy[0], programming_select_n};
    next_m.ce_sy   = {m.ce_sy[0], chip_select_n};
    next_m.rst_sy  = {m.rst_sy[0], counter_reset_oe};
    next_m.pol_sy  = {m.pol_sy[0], reset_active_high};
    next_m.scl_sy  = {m.scl_sy[0], config_serial_clock};
    next_m.sda_sy  = {m.sda_sy[0], config_data_in};
    next_m.g1      = l.gray;
    next_m.g2      = m.g1;
    next_m.scl_d   = m.scl_sy[1];
    next_m.sda_d   = m.sda_sy[1];
    next_m.prog_d  = m.prog_sy[1];
    // chip select only matters in configuration mode
    next_m.low_power = !prog && m.ce_sy[1];  // see [RULE4] see [RULE5]
    next_m.cfg_drive = !prog && !m.ce_sy[1] && (m.rst_sy[1] != m.pol_sy[1])
                       && !m.fuse;  // see [RULE1] see [RULE3] see [RULE9]
    next_m.link_rstn = !prog && !m.ce_sy[1]
                       && (m.rst_sy[1] != m.pol_sy[1]);  // see [RULE2] see [RULE4]
    if (busy)
    begin
      next_m.busy_cnt = m.busy_cnt - 32'h1;
    end
    // low to high on the select pin completes the toggle
    if (m.prog_sy[1] && !m.prog_d && m.clr_pend)
    begin
      next_m.fuse     = 1'b0;  // see [RULE12]
      next_m.clr_pend = 1'b0;
    end
    if (!prog)
    begin
      // address survives only while the part stays in 2-wire mode
      next_m.st      = cfg_eeprom_pkg::TW_IDLE;
      next_m.addr    = 24'h0;  // see [RULE17]
      next_m.sda_low = 1'b0;
    end
    else if (start_c)
    begin
      next_m.st      = cfg_eeprom_pkg::TW_DEV;
      next_m.bitc    = 4'h0;
      next_m.sda_low = 1'b0;
    end
    else if (stop_c)
    begin
      next_m.st      = cfg_eeprom_pkg::TW_IDLE;
      next_m.sda_low = 1'b0;
      next_m.wrote   = 1'b0;
      if (m.wrote && !m.erasing)
      begin
        next_m.busy_cnt = 32'(WR_CYC);
      end
    end
    else
    begin
      case (m.st)
        cfg_eeprom_pkg::TW_DEV, cfg_eeprom_pkg::TW_ADR, cfg_eeprom_pkg::TW_WR:
        begin
          if (scl_rise)
          begin
            next_m.sh   = {m.sh[6:0], m.sda_sy[1]};
            next_m.bitc = m.bitc + 4'h1;
          end
          else if (scl_fall && m.bitc == `BYTE_BITS)
          begin
            next_m.bitc    = 4'h0;
            next_m.sda_low = 1'b1;  // see [RULE8]
            if (m.st == cfg_eeprom_pkg::TW_DEV)
            begin
              if (m.sh[7:1] == DEV_ADDR && !busy)
              begin
                next_m.rw = m.sh[0];
                next_m.st = cfg_eeprom_pkg::TW_DEV_ACK;
              end
              else
              begin
                next_m.sda_low = 1'b0;  // see [RULE18]
                next_m.st      = cfg_eeprom_pkg::TW_IDLE;
              end
            end
            else if (m.st == cfg_eeprom_pkg::TW_ADR)
            begin
              next_m.addr = {m.addr[15:0], m.sh};
              next_m.st   = cfg_eeprom_pkg::TW_ADR_ACK;
            end
            else
            begin
              next_m.st    = cfg_eeprom_pkg::TW_WR_ACK;
              next_m.addr  = m.addr + 24'h1;
              next_m.wrote = 1'b1;
              if (m.addr == `ERASE_ADDR)
              begin
                next_m.erasing    = 1'b1;  // see [RULE15]
                next_m.erase_addr = '0;
                next_m.busy_cnt   = 32'(ERASE_CYC);  // see [RULE16]
              end
              else if (sec_hit)
              begin
                if (rx_byte == `BYTE_ZERO)
                begin
                  next_m.zmask[m.addr[1:0]] = 1'b1;
                  next_m.fmask              = 4'h0;
                  if (m.fuse && !m.erasing)
                  begin
                    next_m.erasing    = 1'b1;  // see [RULE10]
                    next_m.erase_addr = '0;
                    next_m.busy_cnt   = 32'(ERASE_CYC);
                  end
                end
                else if (rx_byte == `BYTE_ONES)
                begin
                  next_m.fmask[m.addr[1:0]] = 1'b1;
                  next_m.zmask              = 4'h0;
                  next_m.zpass              = 2'h0;
                end
                else
                begin
                  next_m.fmask = 4'h0;
                  next_m.zmask = 4'h0;
                  next_m.zpass = 2'h0;
                end
                if (m.addr[1:0] == `SEC_LAST_IDX)
                begin
                  next_m.zmask = 4'h0;
                  next_m.fmask = 4'h0;
                  if ((m.fmask | 4'h8) == `MASK_FULL && rx_byte == `BYTE_ONES)
                  begin
                    next_m.fuse     = 1'b1;  // see [RULE13]
                    next_m.clr_pend = 1'b0;
                  end
                  if ((m.zmask | 4'h8) == `MASK_FULL && rx_byte == `BYTE_ZERO)
                  begin
                    // second complete pass of zeros arms the disable
                    next_m.zpass = (m.zpass == `ZERO_PASSES) ? m.zpass : m.zpass + 2'h1;
                    if (m.zpass != 2'h0)
                    begin
                      next_m.clr_pend = 1'b1;  // see [RULE11]
                    end
                  end
                end
              end
              else
              begin
                mem_we = !m.erasing;
              end
            end
          end
        end
        cfg_eeprom_pkg::TW_DEV_ACK, cfg_eeprom_pkg::TW_ADR_ACK, cfg_eeprom_pkg::TW_WR_ACK:
        begin
          if (scl_fall)
          begin
            next_m.sda_low = 1'b0;
            if (m.st == cfg_eeprom_pkg::TW_DEV_ACK && m.rw)
            begin
              next_m.sh      = rd_byte;
              next_m.sda_low = ~rd_byte[0];  // see [RULE8]
              next_m.bitc    = 4'h1;
              next_m.st      = cfg_eeprom_pkg::TW_RD;
            end
            else if (m.st == cfg_eeprom_pkg::TW_DEV_ACK)
            begin
              next_m.adr_idx = 2'h0;
              next_m.st      = cfg_eeprom_pkg::TW_ADR;
            end
            else if (m.st == cfg_eeprom_pkg::TW_ADR_ACK && m.adr_idx != `ADDR_LAST_IDX)
            begin
              next_m.adr_idx = m.adr_idx + 2'h1;
              next_m.st      = cfg_eeprom_pkg::TW_ADR;
            end
            else
            begin
              next_m.st = cfg_eeprom_pkg::TW_WR;
            end
          end
        end
        cfg_eeprom_pkg::TW_RD:
        begin
          if (scl_fall && m.bitc == `BYTE_BITS)
          begin
            next_m.sda_low = 1'b0;
            next_m.addr    = m.addr + 24'h1;  // see [RULE17]
            next_m.st      = cfg_eeprom_pkg::TW_RD_ACK;
          end
          else if (scl_fall)
          begin
            next_m.sh      = m.sh >> 1;
            next_m.sda_low = ~m.sh[1];
            next_m.bitc    = m.bitc + 4'h1;
          end
        end
        cfg_eeprom_pkg::TW_RD_ACK:
        begin
          if (scl_rise)
          begin
            next_m.rw = ~m.sda_sy[1];
          end
          else if (scl_fall && m.rw)
          begin
            next_m.sh      = rd_byte;
            next_m.sda_low = ~rd_byte[0];
            next_m.bitc    = 4'h1;
            next_m.st      = cfg_eeprom_pkg::TW_RD;
          end
          else if (scl_fall)
          begin
            next_m.st = cfg_eeprom_pkg::TW_IDLE;
          end
        end
        default:
        begin
          next_m.st = cfg_eeprom_pkg::TW_IDLE;
        end
      endcase
    end
    // the sweep takes the write port; it is far shorter than the erase time
    if (m.erasing)
    begin
      mem_we            = 1'b1;
      mem_wa            = m.erase_addr;
      mem_wd            = `BYTE_ONES;
      next_m.erase_addr = m.erase_addr + ADDR_W'(1);
      next_m.erasing    = (m.erase_addr != '1);
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      m         <= '0;
      m.prog_sy <= 2'h3;
      m.prog_d  <= 1'b1;
      m.ce_sy   <= 2'h3;
    end
    else
    begin
      m <= next_m;
    end
  end

  // ------------------------------------------------------------
  // link clock side: configuration read-out counters
  // ------------------------------------------------------------
  always_comb
  begin
    next_d    = d;
    next_d.d1 = mem_rd;  // quasi-static: the byte settles 8 link edges before use
    next_d.d2 = d.d1;
    next_l    = l;
    next_l.bitc = l.bitc + 3'h1;  // see [RULE7]
    if (l.bitc == 3'h0)
    begin
      next_l.sh   = d.d2;
      next_l.addr = l.addr + ADDR_W'(1);
    end
    else
    begin
      next_l.sh = l.sh >> 1;
    end
    next_l.gray = next_l.addr ^ (next_l.addr >> 1);
  end

  always_ff @(posedge config_serial_clock or negedge rstn)
  begin
    if (!rstn)
    begin
      d <= '0;
    end
    else
    begin
      d <= next_d;
    end
  end

  always_ff @(posedge config_serial_clock or negedge m.link_rstn)
  begin
    if (!m.link_rstn)
    begin
      l <= '0;  // see [RULE2]
    end
    else
    begin
      l <= next_l;
    end
  end

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  assign config_data_out = prog ? 1'b0 : l.sh[0];
  assign config_data_oe  = prog ? m.sda_low : m.cfg_drive;  // see [RULE8]
  assign low_power       = m.low_power;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_dev_byte_busy;
    (m.st == cfg_eeprom_pkg::TW_DEV) && scl_fall && (m.bitc == `BYTE_BITS) && busy;
  endsequence

  sequence s_sec_zero_write;
    (m.st == cfg_eeprom_pkg::TW_WR) && scl_fall && (m.bitc == `BYTE_BITS) && sec_hit
    && (rx_byte == `BYTE_ZERO) && m.fuse && !m.erasing && !start_c && !stop_c && prog;
  endsequence

  property p_cfg_gate;
    @(posedge mclk) disable iff (!rstn)
    // the gate is registered, so it answers to the synchronised pin levels of one cycle back
    (!prog && config_data_oe) |-> $past(!m.ce_sy[1] && (m.rst_sy[1] != m.pol_sy[1]));
  endproperty
  a_cfg_gate: assert property (p_cfg_gate) else $error("read-out driven while unselected"); // see [RULE1]

  property p_fuse_mute;
    @(posedge mclk) disable iff (!rstn)
    (m.fuse && !prog) |=> !config_data_oe;
  endproperty
  a_fuse_mute: assert property (p_fuse_mute) else $error("data driven with fuse set"); // see [RULE9]

  property p_low_power;
    @(posedge mclk) disable iff (!rstn)
    (!prog && m.ce_sy[1]) |=> low_power && !m.link_rstn;
  endproperty
  a_low_power: assert property (p_low_power) else $error("deselect not honoured"); // see [RULE4]

  property p_ce_ignored;
    @(posedge mclk) disable iff (!rstn)
    $past(prog) && prog |-> !low_power;
  endproperty
  a_ce_ignored: assert property (p_ce_ignored) else $error("chip select acted in 2-wire mode"); // see [RULE5]

  property p_nack_busy;
    @(posedge mclk) disable iff (!rstn)
    s_dev_byte_busy |=> (m.st == cfg_eeprom_pkg::TW_IDLE) && !m.sda_low;
  endproperty
  a_nack_busy: assert property (p_nack_busy) else $error("address acked while busy"); // see [RULE18]

  property p_clear_erases;
    @(posedge mclk) disable iff (!rstn)
    s_sec_zero_write |=> m.erasing ##1 mem_we[*4];
  endproperty
  a_clear_erases: assert property (p_clear_erases) else $error("fuse clear did not erase"); // see [RULE10]

  property p_erase_busy;
    @(posedge mclk) disable iff (!rstn)
    $rose(m.erasing) |-> busy[*8];
  endproperty
  a_erase_busy: assert property (p_erase_busy) else $error("erase not held busy"); // see [RULE16]

  property p_toggle_clear;
    @(posedge mclk) disable iff (!rstn)
    (m.clr_pend && m.prog_sy[1] && !m.prog_d) |=> !m.fuse;
  endproperty
  a_toggle_clear: assert property (p_toggle_clear) else $error("fuse not cleared on toggle"); // see [RULE12]

  property p_sec_read;
    @(posedge mclk) disable iff (!rstn)
    ((m.st == cfg_eeprom_pkg::TW_DEV_ACK) && m.rw && scl_fall && sec_hit && prog
     && !start_c && !stop_c) |=> (m.sh == {8{$past(m.fuse)}});
  endproperty
  a_sec_read: assert property (p_sec_read) else $error("security byte wrong"); // see [RULE14]

  property p_bit_adv;
    @(posedge config_serial_clock) disable iff (!m.link_rstn)
    (l.bitc == 3'h7) |=> (l.bitc == 3'h0) ##7 (l.bitc == 3'h7);
  endproperty
  a_bit_adv: assert property (p_bit_adv) else $error("bit counter not advancing"); // see [RULE7]

endmodule

`default_nettype wire

// >>> verif/cfg_programmer.sv
// 2-wire programmer and read-out clock source on the link side
`timescale 1ns/1ps
`default_nettype none

module cfg_programmer (
  // link
  output logic      scl,
  output logic      pull_low,
  input  wire logic line
);
  // ----------------------------------------
  // bit and byte level link tasks
  // ----------------------------------------
  // clock parks low between frames; the line is only pulled low, never driven high
  initial
  begin
    scl = 1'b0;
    pull_low = 1'b0;
  end

  task automatic xfer(input logic b, output logic r);
    pull_low = ~b;
    #40;
    scl = 1'b1;
    #40;
    r = line;
    scl = 1'b0;
  endtask

  task automatic start();
    pull_low = 1'b0;
    #40;
    scl = 1'b1;
    #40;
    pull_low = 1'b1;
    #40;
    scl = 1'b0;
  endtask

  task automatic stop();
    pull_low = 1'b1;
    #40;
    scl = 1'b1;
    #40;
    pull_low = 1'b0;
    #40;
    scl = 1'b0;
  endtask

  // eight bits then the acknowledge slot; ack true when the line was low
  task automatic byte_io(input logic [7:0] d, input logic msb, input logic last,
                         output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 0; i < 8; i++)
    begin
      xfer(d[msb ? 7 - i : i], r);
      q[msb ? 7 - i : i] = r;
    end
    xfer(last, r);
    ack = ~r;
  endtask
endmodule

`default_nettype wire

// >>> verif/test_config_eeprom_mode_and_security.sv
// self-checking bench for the configuration eeprom access block
`timescale 1ns/1ps
`default_nettype none
`include "cfg_eeprom_consts.svh"

module test_config_eeprom_mode_and_security;
  // ----------------------------------------
  // clocks, pins and the resolved data line
  // ----------------------------------------
  logic       mclk = 1'b0;
  logic       rstn = 1'b0;
  logic       chip_select_n;
  logic       counter_reset_oe;
  logic       reset_active_high;
  logic       programming_select_n;
  wire logic  scl;
  wire logic  pull_low;
  wire logic  dout;
  wire logic  doe;
  wire logic  low_power;
  wire logic  line;
  int         errors = 0;
  int         total_checks = 0;
  int         cycles = 0;
  logic [7:0] d0;
  logic [7:0] d1;
  logic [7:0] q;
  logic       ack;
  logic       r;

  // pull-up wins when nobody drives
  assign line = (doe ? dout : 1'b1) & ~pull_low;

  always #2.5 mclk = ~mclk;

  cfg_eeprom #(.ADDR_W(8), .WR_CYC(200), .ERASE_CYC(356)) dut_u (
    .mclk(mclk), .rstn(rstn), .config_serial_clock(scl), .config_data_in(line),
    .config_data_out(dout), .config_data_oe(doe), .chip_select_n(chip_select_n),
    .counter_reset_oe(counter_reset_oe), .reset_active_high(reset_active_high),
    .programming_select_n(programming_select_n), .low_power(low_power));

  cfg_programmer pm (.scl(scl), .pull_low(pull_low), .line(line));

  // ----------------------------------------
  // checking and link level tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic gap(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic dev(input logic rw, input logic exp);
    pm.start();
    pm.byte_io({`DEV_ADDR_DEF, rw}, 1'b1, 1'b1, q, ack);
    check({7'h00, ack}, {7'h00, exp});
  endtask

  task automatic addr(input logic [23:0] a);
    dev(1'b0, 1'b1);
    for (int i = 2; i >= 0; i--)
    begin
      pm.byte_io(a[i*8 +: 8], 1'b1, 1'b1, q, ack);
      check({7'h00, ack}, 8'h01);
    end
  endtask

  // the wait after a write covers the write or erase cycle, or is zero where a busy no-acknowledge check follows
  task automatic wr(input logic [23:0] a, input logic [7:0] d, input int w);
    addr(a);
    pm.byte_io(d, 1'b0, 1'b1, q, ack);
    pm.stop();
    gap(w);
  endtask

  // current address read: one byte, then no acknowledge and stop
  task automatic cur(input logic [7:0] exp);
    dev(1'b1, 1'b1);
    pm.byte_io(8'hff, 1'b0, 1'b1, q, ack);
    pm.stop();
    check(q, exp);
  endtask

  task automatic rd(input logic [23:0] a, input logic [7:0] exp);
    addr(a);
    cur(exp);
  endtask

  // a set fuse leaves the line to its pull-up
  function automatic logic [7:0] exp_bit(input logic [15:0] bytes, input int i,
                                         input logic sec);
    return {7'h00, sec | bytes[i]};
  endfunction

  // serial read-out of bytes 0 and 1 with the given reset polarity
  task automatic readout(input logic pol, input logic [15:0] exp, input logic sec);
    reset_active_high = pol;
    counter_reset_oe = pol;
    programming_select_n = 1'b1;
    chip_select_n = 1'b0;
    gap(10);
    check({7'h00, doe}, 8'h00);
    pm.xfer(1'b1, r);
    pm.xfer(1'b1, r);
    counter_reset_oe = ~pol;
    gap(10);
    for (int i = 0; i < 16; i++)
    begin
      pm.xfer(1'b1, r);
      check({7'h00, r}, exp_bit(exp, i, sec));
      check({7'h00, doe}, {7'h00, ~sec});
    end
    chip_select_n = 1'b1;
    gap(10);
    check({6'h00, low_power, doe}, 8'h02);
    chip_select_n = 1'b0;
    counter_reset_oe = pol;
    programming_select_n = 1'b0;
    gap(10);
  endtask

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      errors++;
      finish_test();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    chip_select_n = 1'b1;
    counter_reset_oe = 1'b1;
    reset_active_high = 1'b1;
    programming_select_n = 1'b0;
    void'($urandom(54));
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    gap(16);
    rstn = 1'b1;
    gap(8);
    check({7'h00, low_power}, 8'h00);
    wr(24'h0, d0, 0);
    dev(1'b0, 1'b0);
    pm.stop();
    gap(300);
    wr(24'h1, d1, 300);
    rd(24'h1, d1);
    rd(24'h0, d0);
    cur(d1);
    readout(1'b0, {d1, d0}, 1'b0);
    readout(1'b1, {d1, d0}, 1'b0);
    for (int i = 0; i < 4; i++)
      wr(`SEC_BASE + 24'(i), 8'hff, 300);
    rd(`SEC_BASE, 8'hff);
    readout(1'b1, 16'h0000, 1'b1);
    repeat (2)
      for (int i = 0; i < 4; i++)
        wr(`SEC_BASE + 24'(i), 8'h00, 500);
    rd(24'h0, 8'hff);
    rd(`SEC_BASE + 24'h3, 8'hff);
    readout(1'b0, 16'hffff, 1'b0);
    rd(`SEC_BASE, 8'h00);
    wr(24'h2, d0, 300);
    wr(`ERASE_ADDR, d1, 0);
    dev(1'b0, 1'b0);
    pm.stop();
    gap(500);
    rd(24'h2, 8'hff);
    finish_test();
  end
endmodule

`default_nettype wire
